// ### verilog/pio_point_pkg.sv
// Shared constants and types for the seven-point direct I/O block.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package pio_point_pkg;

	// Widths of the motion-core quantities
	localparam int POS_W = 16;
	localparam int TRQ_W = 12;
	localparam int CUR_W = 12;
	localparam int NUM_POS = 7;
	localparam int IDX_W = 3;

	// Bit positions inside the synchronised PLC input vector
	localparam int IN_GOTO_LSB = 0;
	localparam int IN_BRAKE = 7;
	localparam int IN_MODE = 8;
	localparam int IN_HOME = 9;
	localparam int IN_PAUSE = 10;
	localparam int IN_CLEAR = 11;
	localparam int IN_SERVO = 12;
	localparam int IN_ESTOP = 13;
	localparam int IN_W = 14;

	// Reset values of the input samples (all lines read low, so pause reads active)
	localparam logic [IN_W-1:0] IN_RST = 14'h0000;

	// Reset values of flags and outputs
	localparam logic [NUM_POS-1:0] ARRIVED_RST = 7'h00;
	localparam logic [IDX_W-1:0] TARGET_RST = 3'h0;
	localparam logic FLAG_RST = 1'b0;
	localparam logic FLAG_N_RST = 1'b1;

	// Motion sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_MOVE = 3'h2,
		ST_HOME = 3'h4
	} motion_state_t;

	// Index of the lowest set start line, lowest number wins
	function automatic logic [IDX_W-1:0] lowest_set(
		input logic [NUM_POS-1:0] v
	);
		logic [IDX_W-1:0] r;
		r = TARGET_RST;
		for (int i = NUM_POS - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IDX_W'(i);
			end
		end
		return r;
	endfunction

endpackage

// ### verilog/pin_sync_edge.sv
// Two-stage synchroniser with rising-edge detection for PLC pins.
// Assumes pins are asynchronous to i_ref_clk.
`timescale 1ns/1ns
`default_nettype none
module pin_sync_edge #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_pins,
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_rise
);
	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;

	// First stage feeds only the second stage
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			meta <= RST_VAL;
			stable <= RST_VAL;
			prev <= RST_VAL;
		end else begin
			meta <= i_pins;
			stable <= meta;
			prev <= stable;
		end
	end

	// Edge found by comparing successive stable samples
	assign o_level = stable;
	assign o_rise = stable & ~prev;
endmodule
`default_nettype wire

// ### verilog/range_check.sv
// Inclusive window comparison of a signed position.
// Assumes lo <= hi; an inverted window never matches.
`timescale 1ns/1ns
`default_nettype none
module range_check
	import pio_point_pkg::*;
(
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_value,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_lo,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_hi,
	output logic o_inside
);
	// Both bounds count as inside
	assign o_inside = (i_value >= i_lo) && (i_value <= i_hi);
endmodule
`default_nettype wire

// ### verilog/point_io_ctrl.sv
// Seven-point direct-command discrete I/O logic of a positioner.
// Assumes a motion core on the same clock that runs moves and homing,
// reports position, torque and current, and flags alarms and stops.
//
// Operation
// (R1) Rising start line n begins a move to stored position n.
// (R2) Arrival flag n rises when the move to position n completes.
// (R3) Brake release input frees a fitted brake regardless of servo.
// (R4) Mode select level chooses automatic or hand operation.
// (R5) Rising home input starts the homing sequence.
// (R6) Pause low decelerates to a stop; motion only while it is high.
// (R7) Rising alarm clear removes the present alarm.
// (R8) Servo energised exactly while servo enable is high.
// (R9) Zone flag high inside parameter range, only after homing.
// (R10) Table range flag high inside entry range after a move command.
// (R11) Mode status low in automatic, high in hand operation.
// (R12) Homing done low from power-up until homing completes.
// (R13) Ready output needs no e-stop, drive power, servo on, pause high.
// (R14) Drive ready whenever servo is on and controller can operate.
// (R15) E-stop status output low while an emergency stop holds.
// (R16) Fault output high normally, low when an alarm occurs.
// (R17) Load output high when torque exceeds threshold inside range.
// (R18) Current flag high when motor current reaches its threshold.
// (R19) Inputs synchronised, edges from samples, lowest start line wins.
// (R20) All arrival flags clear when a new direct move begins.
`timescale 1ns/1ns
`default_nettype none
module point_io_ctrl
	import pio_point_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// PLC pins
	input wire logic i_goto_pos_0,
	input wire logic i_goto_pos_1,
	input wire logic i_goto_pos_2,
	input wire logic i_goto_pos_3,
	input wire logic i_goto_pos_4,
	input wire logic i_goto_pos_5,
	input wire logic i_goto_pos_6,
	input wire logic i_brake_force_release,
	input wire logic i_mode_select,
	input wire logic i_home,
	input wire logic i_pause_n,
	input wire logic i_alarm_clear,
	input wire logic i_servo_enable,
	input wire logic i_estop,
	// Motion core status, same clock
	input wire logic i_has_brake,
	input wire logic i_drive_power,
	input wire logic i_move_done,
	input wire logic i_home_done,
	input wire logic i_alarm_event,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_position,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_zone_lo,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_zone_hi,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_table_lo,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_table_hi,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_check_lo,
	input wire logic signed [pio_point_pkg::POS_W-1:0] i_check_hi,
	input wire logic [pio_point_pkg::TRQ_W-1:0] i_torque_cmd,
	input wire logic [pio_point_pkg::TRQ_W-1:0] i_torque_limit,
	input wire logic [pio_point_pkg::CUR_W-1:0] i_motor_current,
	input wire logic [pio_point_pkg::CUR_W-1:0] i_current_limit,
	// Commands to the motion core
	output logic o_move_start,
	output logic [pio_point_pkg::IDX_W-1:0] o_move_target,
	output logic o_home_start,
	output logic o_decel_stop,
	output logic o_alarm_reset,
	output logic o_servo_energize,
	output logic o_brake_release,
	output logic o_hand_mode,
	// PLC outputs
	output logic o_arrived_pos_0,
	output logic o_arrived_pos_1,
	output logic o_arrived_pos_2,
	output logic o_arrived_pos_3,
	output logic o_arrived_pos_4,
	output logic o_arrived_pos_5,
	output logic o_arrived_pos_6,
	output logic o_zone_flag,
	output logic o_table_range_flag,
	output logic o_hand_mode_status,
	output logic o_homing_done,
	output logic o_power_up_ready,
	output logic o_drive_ready,
	output logic o_estop_active_n,
	output logic o_fault_n,
	output logic o_load_flag,
	output logic o_current_threshold_flag
);
	logic [IN_W-1:0] pins;
	logic [IN_W-1:0] lvl;
	logic [IN_W-1:0] rise;
	logic [NUM_POS-1:0] start_rise;
	logic start_any;
	logic [IDX_W-1:0] start_idx;
	logic brake_lvl;
	logic mode_lvl;
	logic home_rise;
	logic pause_lvl;
	logic clear_rise;
	logic servo_lvl;
	logic estop_lvl;
	logic can_move;
	logic abort;
	logic start_ok;
	logic home_ok;
	logic in_zone;
	logic in_table;
	logic in_check;
	motion_state_t state;
	motion_state_t next_state;
	logic [NUM_POS-1:0] arrived;
	logic [NUM_POS-1:0] next_arrived;
	logic [IDX_W-1:0] target;
	logic [IDX_W-1:0] next_target;
	logic homed;
	logic next_homed;
	logic cmd_seen;
	logic next_cmd_seen;
	logic fault;
	logic next_fault;
	logic next_move_start;
	logic next_home_start;

	// Gather the PLC pins into one vector
	assign pins = {i_estop, i_servo_enable, i_alarm_clear, i_pause_n,
		i_home, i_mode_select, i_brake_force_release, i_goto_pos_6,
		i_goto_pos_5, i_goto_pos_4, i_goto_pos_3, i_goto_pos_2,
		i_goto_pos_1, i_goto_pos_0};

	// Two flops and edge detection on every pin
	pin_sync_edge #(
		.W(IN_W),
		.RST_VAL(IN_RST)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_pins(pins),
		.o_level(lvl),
		.o_rise(rise)
	); // see (R19)

	// Named views of the synchronised pins
	assign start_rise = rise[IN_GOTO_LSB +: NUM_POS];
	assign brake_lvl = lvl[IN_BRAKE];
	assign mode_lvl = lvl[IN_MODE];
	assign home_rise = rise[IN_HOME];
	assign pause_lvl = lvl[IN_PAUSE];
	assign clear_rise = rise[IN_CLEAR];
	assign servo_lvl = lvl[IN_SERVO];
	assign estop_lvl = lvl[IN_ESTOP];

	// Lowest-numbered start line is taken
	assign start_any = |start_rise;
	assign start_idx = lowest_set(start_rise); // see (R19)

	// Motion is allowed only in automatic mode, paused high, servo up
	assign can_move = pause_lvl && servo_lvl && !fault && !mode_lvl &&
		!estop_lvl && i_drive_power; // see (R6)
	assign abort = !servo_lvl || fault || estop_lvl; // see (R8)
	assign start_ok = start_any && can_move;
	assign home_ok = home_rise && can_move;

	// Position windows
	range_check u_zone (
		.i_value(i_position),
		.i_lo(i_zone_lo),
		.i_hi(i_zone_hi),
		.o_inside(in_zone)
	);
	range_check u_table (
		.i_value(i_position),
		.i_lo(i_table_lo),
		.i_hi(i_table_hi),
		.o_inside(in_table)
	);
	range_check u_check (
		.i_value(i_position),
		.i_lo(i_check_lo),
		.i_hi(i_check_hi),
		.o_inside(in_check)
	);

	// Sequencer next-state and flag updates
	always_comb begin
		next_state = state;
		next_arrived = arrived;
		next_target = target;
		next_homed = homed;
		next_cmd_seen = cmd_seen;
		next_move_start = 1'b0;
		next_home_start = 1'b0;
		case (state)
			ST_IDLE: begin
				if (start_ok) begin
					next_state = ST_MOVE; // see (R1)
					next_target = start_idx;
					next_arrived = ARRIVED_RST; // see (R20)
					next_cmd_seen = 1'b1; // see (R10)
					next_move_start = 1'b1;
				end else if (home_ok) begin
					next_state = ST_HOME; // see (R5)
					next_home_start = 1'b1;
				end
			end
			ST_MOVE: begin
				if (abort) begin
					next_state = ST_IDLE;
				end else if (start_ok) begin
					next_target = start_idx; // see (R1)
					next_arrived = ARRIVED_RST; // see (R20)
					next_move_start = 1'b1;
				end else if (i_move_done) begin
					next_state = ST_IDLE;
					next_arrived[target] = 1'b1; // see (R2)
				end
			end
			ST_HOME: begin
				if (abort) begin
					next_state = ST_IDLE;
				end else if (i_home_done) begin
					next_state = ST_IDLE;
					next_homed = 1'b1; // see (R12)
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Alarm latch: a new alarm wins over a clear in the same cycle
	assign next_fault = i_alarm_event || (fault && !clear_rise); // see (R7)

	// Sequencer registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			arrived <= ARRIVED_RST;
			target <= TARGET_RST;
			homed <= FLAG_RST;
			cmd_seen <= FLAG_RST;
			fault <= FLAG_RST;
		end else begin
			state <= next_state;
			arrived <= next_arrived;
			target <= next_target;
			homed <= next_homed;
			cmd_seen <= next_cmd_seen;
			fault <= next_fault; // see (R16)
		end
	end

	// Registered commands to the motion core
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_move_start <= FLAG_RST;
			o_move_target <= TARGET_RST;
			o_home_start <= FLAG_RST;
			o_decel_stop <= FLAG_N_RST;
			o_alarm_reset <= FLAG_RST;
			o_servo_energize <= FLAG_RST;
			o_brake_release <= FLAG_RST;
			o_hand_mode <= FLAG_RST;
		end else begin
			o_move_start <= next_move_start;
			o_move_target <= next_target;
			o_home_start <= next_home_start;
			o_decel_stop <= !pause_lvl; // see (R6)
			o_alarm_reset <= clear_rise; // see (R7)
			o_servo_energize <= servo_lvl; // see (R8)
			o_brake_release <= i_has_brake && (brake_lvl || servo_lvl); // see (R3)
			o_hand_mode <= mode_lvl; // see (R4)
		end
	end

	// Registered status to the PLC
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_zone_flag <= FLAG_RST;
			o_table_range_flag <= FLAG_RST;
			o_hand_mode_status <= FLAG_RST;
			o_homing_done <= FLAG_RST;
			o_power_up_ready <= FLAG_RST;
			o_drive_ready <= FLAG_RST;
			o_estop_active_n <= FLAG_N_RST;
			o_fault_n <= FLAG_N_RST;
			o_load_flag <= FLAG_RST;
			o_current_threshold_flag <= FLAG_RST;
		end else begin
			o_zone_flag <= homed && in_zone; // see (R9)
			o_table_range_flag <= cmd_seen && in_table; // see (R10)
			o_hand_mode_status <= mode_lvl; // see (R11)
			o_homing_done <= homed; // see (R12)
			o_power_up_ready <= !estop_lvl && i_drive_power &&
				servo_lvl && pause_lvl; // see (R13)
			o_drive_ready <= servo_lvl && i_drive_power && !fault &&
				!estop_lvl; // see (R14)
			o_estop_active_n <= !estop_lvl; // see (R15)
			o_fault_n <= !fault; // see (R16)
			o_load_flag <= in_check &&
				(i_torque_cmd > i_torque_limit); // see (R17)
			o_current_threshold_flag <=
				(i_motor_current >= i_current_limit); // see (R18)
		end
	end

	// Arrival flags leave as separate pins
	assign o_arrived_pos_0 = arrived[0];
	assign o_arrived_pos_1 = arrived[1];
	assign o_arrived_pos_2 = arrived[2];
	assign o_arrived_pos_3 = arrived[3];
	assign o_arrived_pos_4 = arrived[4];
	assign o_arrived_pos_5 = arrived[5];
	assign o_arrived_pos_6 = arrived[6];

	// Checks on the sequencer and status outputs
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_start_launch: assert property ( // see (R1)
		(state == ST_IDLE && start_ok) |=>
			(o_move_start && state == ST_MOVE &&
			o_move_target == $past(start_idx))
	) else $error("start edge did not launch a move");

	a_lowest_wins: assert property ( // see (R19)
		(start_ok && start_rise[0] && state != ST_HOME) |=>
			(o_move_target == TARGET_RST)
	) else $error("lowest start line not taken");

	a_arrive_flag: assert property ( // see (R2)
		(state == ST_MOVE && !abort && !start_ok && i_move_done) |=>
			(arrived[$past(target)] && state == ST_IDLE)
	) else $error("arrival flag missing after move done");

	a_arrive_clear: assert property ( // see (R20)
		o_move_start |-> (arrived == ARRIVED_RST)
	) else $error("arrival flags not cleared on new move");

	a_home_start: assert property ( // see (R5)
		(state == ST_IDLE && home_ok && !start_ok) |=>
			(o_home_start && state == ST_HOME)
	) else $error("home edge did not start homing");

	a_pause_blocks: assert property ( // see (R6)
		!pause_lvl |=> (o_decel_stop && !o_move_start && !o_home_start)
	) else $error("motion started while paused");

	a_servo_drop: assert property ( // see (R8)
		$fell(servo_lvl) |=> (!o_servo_energize && state == ST_IDLE)
	) else $error("servo drop did not de-energise");

	a_brake_force: assert property ( // see (R3)
		(brake_lvl && i_has_brake) |=> o_brake_release
	) else $error("brake not released on force input");

	a_homed_sticky: assert property ( // see (R12)
		o_homing_done |=> o_homing_done
	) else $error("homing done fell");

	a_zone_gate: assert property ( // see (R9)
		!homed |=> !o_zone_flag
	) else $error("zone flag high before homing");

	a_fault_set: assert property ( // see (R16)
		i_alarm_event |=> ##1 !o_fault_n
	) else $error("alarm did not pull fault low");

	a_fault_clear: assert property ( // see (R7)
		(fault && clear_rise && !i_alarm_event) |=> ##1 o_fault_n
	) else $error("alarm clear did not restore fault");

	a_clear_pulse: assert property ( // see (R7)
		clear_rise |=> o_alarm_reset
	) else $error("alarm clear edge gave no reset pulse");

	a_ready_gate: assert property ( // see (R13)
		o_power_up_ready |-> (o_estop_active_n && !o_decel_stop)
	) else $error("ready while stopped");

	c_move_done: cover property (
		o_move_start ##[1:1000] (|arrived)
	);
	c_homing: cover property (o_home_start ##[1:1000] o_homing_done);
	c_clear: cover property (!o_fault_n ##[1:1000] o_fault_n);
	c_retarget: cover property (
		state == ST_MOVE && start_ok && !abort
	);
endmodule
`default_nettype wire

// ### test/motion_core_model.sv
// Behavioural motion core answering move and homing launches.
// Assumes the block's clock and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module motion_core_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_move_start,
	input wire logic i_home_start,
	input wire logic i_slow,
	output logic o_move_done,
	output logic o_home_done
);
	logic [5:0] cnt;
	logic homing;

	// Travel time countdown; a new launch restarts it, done is one pulse
	always_ff @(posedge i_ref_clk) begin
		o_move_done <= 1'b0;
		o_home_done <= 1'b0;
		if (!i_rst_n) begin
			cnt <= 6'h00;
			homing <= 1'b0;
		end else if (i_move_start | i_home_start) begin
			cnt <= i_slow ? 6'h28 : 6'h04;
			homing <= i_home_start;
		end else if (cnt == 6'h01) begin
			cnt <= 6'h00;
			o_move_done <= !homing;
			o_home_done <= homing;
		end else if (cnt != 6'h00) begin
			cnt <= cnt - 6'h01;
		end
	end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the seven-point direct I/O block.
// Assumes the motion core model answers every launch.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pio_point_pkg::*;
	logic clk, rst_n, has_brake, drive_power, alarm_ev, slow;
	logic [IN_W-1:0] pin;
	logic signed [POS_W-1:0] pos, chk_hi;
	logic [TRQ_W-1:0] trq, tlim;
	logic [CUR_W-1:0] cur, clim;
	logic mv_start, hm_start, mv_done, hm_done;
	logic [IDX_W-1:0] tgt;
	logic [NUM_POS-1:0] arr;
	logic zone, tbl, hand_st, hdone, pready, dready, estop_n, fault_n;
	logic load, curf, brake, decel, hand, servo, alm_rst;
	int bad_count, num_checks, cycles, rst_pulses;

	// Block under test with fixed zone and table windows and check window low end; check window high end and limits driven by the bench
	point_io_ctrl u_point_io_ctrl (
		.i_ref_clk(clk), .i_rst_n(rst_n),
		.i_goto_pos_0(pin[0]), .i_goto_pos_1(pin[1]), .i_goto_pos_2(pin[2]),
		.i_goto_pos_3(pin[3]), .i_goto_pos_4(pin[4]), .i_goto_pos_5(pin[5]),
		.i_goto_pos_6(pin[6]), .i_brake_force_release(pin[IN_BRAKE]),
		.i_mode_select(pin[IN_MODE]), .i_home(pin[IN_HOME]),
		.i_pause_n(pin[IN_PAUSE]), .i_alarm_clear(pin[IN_CLEAR]),
		.i_servo_enable(pin[IN_SERVO]), .i_estop(pin[IN_ESTOP]),
		.i_has_brake(has_brake), .i_drive_power(drive_power),
		.i_move_done(mv_done), .i_home_done(hm_done),
		.i_alarm_event(alarm_ev), .i_position(pos),
		.i_zone_lo(16'h0064), .i_zone_hi(16'h00C8),
		.i_table_lo(16'h0096), .i_table_hi(16'h012C),
		.i_check_lo(16'h0000), .i_check_hi(chk_hi),
		.i_torque_cmd(trq), .i_torque_limit(tlim),
		.i_motor_current(cur), .i_current_limit(clim),
		.o_move_start(mv_start), .o_move_target(tgt),
		.o_home_start(hm_start), .o_decel_stop(decel),
		.o_alarm_reset(alm_rst),
		.o_servo_energize(servo), .o_brake_release(brake),
		.o_hand_mode(hand), .o_arrived_pos_0(arr[0]),
		.o_arrived_pos_1(arr[1]), .o_arrived_pos_2(arr[2]),
		.o_arrived_pos_3(arr[3]), .o_arrived_pos_4(arr[4]),
		.o_arrived_pos_5(arr[5]), .o_arrived_pos_6(arr[6]),
		.o_zone_flag(zone), .o_table_range_flag(tbl),
		.o_hand_mode_status(hand_st), .o_homing_done(hdone),
		.o_power_up_ready(pready), .o_drive_ready(dready),
		.o_estop_active_n(estop_n), .o_fault_n(fault_n),
		.o_load_flag(load), .o_current_threshold_flag(curf)
	);

	motion_core_model u_motion_core_model (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_move_start(mv_start),
		.i_home_start(hm_start), .i_slow(slow),
		.o_move_done(mv_done), .o_home_done(hm_done)
	);

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (alm_rst === 1'b1) begin
			rst_pulses++;
		end
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Pin level change, held long enough to pass the synchroniser
	task automatic set_pin(input int b, input logic v);
		@(posedge clk);
		pin[b] <= v;
		tick(5);
	endtask

	task automatic go(input int b);
		set_pin(b, 1'b1);
		set_pin(b, 1'b0);
	endtask

	task automatic wait_arr(input logic [NUM_POS-1:0] e);
		for (int k = 0; k < 200 && arr !== e; k++) tick(1);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{rst_n, alarm_ev, slow, trq, cur} = '0;
		{tlim, clim, chk_hi} = {12'h100, 12'h100, 16'h0032};
		{has_brake, drive_power} = 2'b11;
		pin = '0;
		pin[IN_PAUSE] = 1'b1;
		pos = 16'h0096;
		{bad_count, num_checks, cycles, rst_pulses} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		check("fault_n", fault_n, 1);
		check("estop_n", estop_n, 1);
		check("hdone", hdone, 0);
		check("arrived", arr, 0);
		set_pin(IN_SERVO, 1'b1);
		check("servo", servo, 1);
		check("dready", dready, 1);
		check("pready", pready, 1);
		check("zone early", zone, 0);
		check("table early", tbl, 0);
		set_pin(IN_PAUSE, 1'b0);
		check("decel", decel, 1);
		check("pready paused", pready, 0);
		set_pin(IN_PAUSE, 1'b1);
		check("decel off", decel, 0);
		set_pin(IN_ESTOP, 1'b1);
		check("estop_n on", estop_n, 0);
		check("dready estop", dready, 0);
		set_pin(IN_ESTOP, 1'b0);
		@(posedge clk);
		drive_power <= 1'b0;
		tick(3);
		check("pready power", pready, 0);
		check("dready power", dready, 0);
		@(posedge clk);
		drive_power <= 1'b1;
		tick(3);
		check("dready back", dready, 1);
		$display("test status done");
		go(IN_HOME);
		for (int k = 0; k < 200 && hdone !== 1'b1; k++) tick(1);
		check("hdone", hdone, 1);
		check("zone in", zone, 1);
		@(posedge clk);
		pos <= 16'h00FA;
		tick(3);
		check("zone out", zone, 0);
		$display("test homing done");
		for (int n = 0; n < NUM_POS; n++) begin
			go(n);
			wait_arr(7'(1 << n));
			check("arrived", arr, 16'(1 << n));
			check("target", tgt, n[15:0]);
		end
		check("table in", tbl, 1);
		@(posedge clk);
		pin[5] <= 1'b1;
		pin[3] <= 1'b1;
		tick(5);
		@(posedge clk);
		pin[5] <= 1'b0;
		pin[3] <= 1'b0;
		wait_arr(7'h08);
		check("lowest", arr, 16'h0008);
		@(posedge clk);
		slow <= 1'b1;
		go(2);
		go(4);
		wait_arr(7'h10);
		check("retarget", arr, 16'h0010);
		@(posedge clk);
		slow <= 1'b0;
		$display("test moves done");
		set_pin(IN_MODE, 1'b1);
		check("hand status", hand_st, 1);
		check("hand", hand, 1);
		go(6);
		tick(20);
		check("hand refuses", arr, 16'h0010);
		set_pin(IN_MODE, 1'b0);
		check("auto status", hand_st, 0);
		@(posedge clk);
		alarm_ev <= 1'b1;
		@(posedge clk);
		alarm_ev <= 1'b0;
		tick(2);
		check("fault", fault_n, 0);
		go(0);
		tick(20);
		check("fault refuses", arr, 16'h0010);
		go(IN_CLEAR);
		check("cleared", fault_n, 1);
		check("reset pulses", rst_pulses[15:0], 1);
		$display("test modes done");
		set_pin(IN_SERVO, 1'b0);
		check("servo off", servo, 0);
		check("brake held", brake, 0);
		set_pin(IN_BRAKE, 1'b1);
		check("brake free", brake, 1);
		@(posedge clk);
		has_brake <= 1'b0;
		tick(3);
		check("no brake", brake, 0);
		@(posedge clk);
		{pos, trq, cur} <= {16'h0020, 12'h100, 12'h0FF};
		tick(3);
		check("load equal", load, 0);
		check("current below", curf, 0);
		@(posedge clk);
		{trq, cur} <= {12'h101, 12'h100};
		tick(3);
		check("load over", load, 1);
		check("current reach", curf, 1);
		@(posedge clk);
		pos <= 16'h0040;
		tick(3);
		check("load outside", load, 0);
		@(posedge clk);
		chk_hi <= 16'h0040;
		tick(3);
		check("load edge", load, 1);
		@(posedge clk);
		{tlim, clim} <= {12'h101, 12'h101};
		tick(3);
		check("load at limit", load, 0);
		check("current under", curf, 0);
		$display("test flags done");
		report_and_stop();
	end
endmodule
`default_nettype wire
